// file: src/elc_pkg.sv
// Package: register map, field masks and reset values of the line controller
package elc_pkg;
  localparam int          ELC_LINES   = 28;
  localparam logic [31:0] ELC_BASE    = 32'h4001_0400;
  localparam logic [11:0] ELC_WIN_MSK = 12'hfff;
  localparam logic [4:0]  OFS_IRQ_MASK  = 5'h00;
  localparam logic [4:0]  OFS_WAKE_MASK = 5'h04;
  localparam logic [4:0]  OFS_RISE_SEL  = 5'h08;
  localparam logic [4:0]  OFS_FALL_SEL  = 5'h0c;
  localparam logic [4:0]  OFS_SW_TRIG   = 5'h10;
  localparam logic [4:0]  OFS_PENDING   = 5'h14;
  localparam logic [27:0] RST_IRQ_MASK  = 28'hf94_0000;
  localparam logic [27:0] RST_ZERO      = 28'h000_0000;
  // Lines 0-17, 19 and 21 have edge selects, software trigger and pending
  localparam logic [27:0] TRIG_LINES    = 28'h02b_ffff;
  localparam logic [31:0] RD_ZERO       = 32'h0000_0000;
endpackage

// file: src/elc_sync.sv
// Two-flop synchroniser for the line inputs
`timescale 1ns/10ps
`default_nettype none
module elc_sync (
  input  wire logic        i_mclk,  // bus clock
  input  wire logic        i_rst_n, // sync reset, active low
  input  wire logic [27:0] i_async, // raw lines
  output logic      [27:0] o_sync   // synchronised lines
);
  logic [27:0] meta;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      meta   <= 28'h000_0000;
      o_sync <= 28'h000_0000;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule
`default_nettype wire

// file: src/elc_top.sv
// External line edge interrupt and event controller with APB slave
`timescale 1ns/10ps
`default_nettype none
module elc_top (
  input  wire logic        i_mclk,    // bus clock, 100 MHz
  input  wire logic        i_rst_n,   // sync reset, active low
  input  wire logic        i_psel,    // APB select
  input  wire logic        i_penable, // APB enable
  input  wire logic        i_pwrite,  // APB direction
  input  wire logic [31:0] i_paddr,   // APB byte address
  input  wire logic [31:0] i_pwdata,  // APB write data
  output logic      [31:0] o_prdata,  // APB read data
  output logic             o_pready,  // APB ready
  output logic             o_pslverr, // APB error
  input  wire logic [27:0] i_line,    // trigger lines from sources
  output logic      [27:0] o_irq,     // interrupt request per line
  output logic      [27:0] o_event    // one-cycle event pulse per line
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [27:0] line_irq_mask;
  logic [27:0] line_wake_signal_mask;
  logic [27:0] rising_edge_select;
  logic [27:0] falling_edge_select;
  logic [27:0] software_trigger;
  logic [27:0] line_pending_flags;

  logic [27:0] line_sync;
  logic [27:0] line_prev;
  logic [27:0] rise_hit;
  logic [27:0] fall_hit;
  logic [27:0] sw_hit;
  logic [27:0] next_trigger;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  logic        acc;
  logic        wr;
  logic        hit;
  logic [4:0]  ofs;

  function automatic logic is_reg(input logic [4:0] o);
    is_reg = (o == elc_pkg::OFS_IRQ_MASK) || (o == elc_pkg::OFS_WAKE_MASK)
          || (o == elc_pkg::OFS_RISE_SEL) || (o == elc_pkg::OFS_FALL_SEL)
          || (o == elc_pkg::OFS_SW_TRIG)  || (o == elc_pkg::OFS_PENDING);
  endfunction

  always_comb begin
    acc = i_psel && i_penable;
    ofs = i_paddr[4:0];
    // Upper address bits belong to the interconnect; only the window counts
    hit = is_reg(ofs) && (i_paddr[11:5] == 7'h00);
    wr  = acc && i_pwrite && hit;
  end

  // Zero wait states; unmapped offsets answer with an error
  assign o_pready  = 1'b1;
  assign o_pslverr = acc && !hit;

  // ****************************************************************
  // Write strobes
  // ****************************************************************
  // One decode per register keeps every write path on the same terms
  logic        wr_irq_mask;
  logic        wr_wake_mask;
  logic        wr_rise_sel;
  logic        wr_fall_sel;
  logic        wr_sw_trig;
  logic        wr_pending;

  function automatic logic wr_to(input logic       w,
                                 input logic [4:0] o,
                                 input logic [4:0] t);
    wr_to = w && (o == t);
  endfunction

  always_comb begin
    wr_irq_mask  = wr_to(wr, ofs, elc_pkg::OFS_IRQ_MASK);
    wr_wake_mask = wr_to(wr, ofs, elc_pkg::OFS_WAKE_MASK);
    wr_rise_sel  = wr_to(wr, ofs, elc_pkg::OFS_RISE_SEL);
    wr_fall_sel  = wr_to(wr, ofs, elc_pkg::OFS_FALL_SEL);
    wr_sw_trig   = wr_to(wr, ofs, elc_pkg::OFS_SW_TRIG);
    wr_pending   = wr_to(wr, ofs, elc_pkg::OFS_PENDING);
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      line_irq_mask <= elc_pkg::RST_IRQ_MASK;
    end else if (wr_irq_mask) begin
      line_irq_mask <= i_pwdata[27:0];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      line_wake_signal_mask <= elc_pkg::RST_ZERO;
    end else if (wr_wake_mask) begin
      line_wake_signal_mask <= i_pwdata[27:0];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rising_edge_select <= elc_pkg::RST_ZERO;
    end else if (wr_rise_sel) begin
      rising_edge_select <= i_pwdata[27:0] & elc_pkg::TRIG_LINES;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      falling_edge_select <= elc_pkg::RST_ZERO;
    end else if (wr_fall_sel) begin
      falling_edge_select <= i_pwdata[27:0] & elc_pkg::TRIG_LINES;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      software_trigger <= elc_pkg::RST_ZERO;
    end else if (wr_sw_trig) begin
      software_trigger <= i_pwdata[27:0] & elc_pkg::TRIG_LINES;
    end
  end

  // ****************************************************************
  // Line sampling and edge detection
  // ****************************************************************
  elc_sync u_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_async (i_line),
    .o_sync  (line_sync)
  );

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      line_prev <= elc_pkg::RST_ZERO;
    end else begin
      line_prev <= line_sync;
    end
  end

  always_comb begin
    rise_hit = line_sync & ~line_prev & rising_edge_select;
    fall_hit = ~line_sync & line_prev & falling_edge_select;
    // Software trigger fires on a write of one to a bit that holds zero, like an edge
    sw_hit   = wr_sw_trig
             ? (i_pwdata[27:0] & elc_pkg::TRIG_LINES & ~software_trigger)
             : elc_pkg::RST_ZERO;
    next_trigger = rise_hit | fall_hit | sw_hit;
  end

  // ****************************************************************
  // Pending flags
  // ****************************************************************
  // Pending is cleared at reset here although software must not rely on it
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      line_pending_flags <= elc_pkg::RST_ZERO;
    end else if (wr_pending) begin
      // Set wins over clear in the same cycle; zeros leave bits alone
      line_pending_flags <= (line_pending_flags & ~i_pwdata[27:0])
                          | next_trigger;
    end else begin
      line_pending_flags <= line_pending_flags | next_trigger;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_event <= elc_pkg::RST_ZERO;
    end else begin
      o_event <= next_trigger & line_wake_signal_mask;
    end
  end

  assign o_irq = line_pending_flags & line_irq_mask;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_prdata <= elc_pkg::RD_ZERO;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      unique case (i_paddr[4:0])
        elc_pkg::OFS_IRQ_MASK:  o_prdata <= {4'h0, line_irq_mask};
        elc_pkg::OFS_WAKE_MASK: o_prdata <= {4'h0, line_wake_signal_mask};
        elc_pkg::OFS_RISE_SEL:  o_prdata <= {4'h0, rising_edge_select};
        elc_pkg::OFS_FALL_SEL:  o_prdata <= {4'h0, falling_edge_select};
        elc_pkg::OFS_SW_TRIG:   o_prdata <= {4'h0, software_trigger};
        elc_pkg::OFS_PENDING:   o_prdata <= {4'h0, line_pending_flags};
        default:                o_prdata <= elc_pkg::RD_ZERO;
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Line 0 stands for every line; the trigger logic is purely bitwise
  irq_gate_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (next_trigger[0] && line_irq_mask[0] && !wr_irq_mask) |=> o_irq[0])
    else $error("masked trigger raised no irq");

  mask_reset_a: assert property (@(posedge i_mclk)
    !i_rst_n |=> line_irq_mask == 28'hf94_0000)
    else $error("irq mask reset value wrong");

  rise_set_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (line_sync[0] && !line_prev[0] && rising_edge_select[0])
      |=> line_pending_flags[0])
    else $error("rising edge did not set pending");

  fall_set_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (!line_sync[0] && line_prev[0] && falling_edge_select[0])
      |=> line_pending_flags[0])
    else $error("falling edge did not set pending");

  no_sel_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (rising_edge_select[1] == 1'b0 && falling_edge_select[1] == 1'b0
      && !sw_hit[1] && !line_pending_flags[1]) |=> !line_pending_flags[1])
    else $error("unselected line became pending");

  clear_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (wr && ofs == elc_pkg::OFS_PENDING && i_pwdata[2] && !next_trigger[2])
      |=> !line_pending_flags[2])
    else $error("write one did not clear pending");

  sw_trig_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (wr && ofs == elc_pkg::OFS_SW_TRIG && i_pwdata[3] && !software_trigger[3])
      |=> line_pending_flags[3])
    else $error("software trigger did not set pending");

  event_pulse_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    o_event[0] |-> $past(next_trigger[0]) && $past(line_wake_signal_mask[0]))
    else $error("event without masked trigger");

  event_mask_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (next_trigger[0] && line_wake_signal_mask[0]) |=> o_event[0])
    else $error("masked event missing");

  sync_pipe_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    ($past(i_rst_n) && $past(i_rst_n, 2)) |-> line_sync == $past(i_line, 2))
    else $error("line synchroniser not two stages");

  both_edge_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (line_sync[0] != line_prev[0] && rising_edge_select[0]
      && falling_edge_select[0]) |=> line_pending_flags[0])
    else $error("both-edge line missed an edge");

  event_one_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (o_event[0] && !next_trigger[0]) |=> !o_event[0])
    else $error("event pulse longer than one cycle");

  event_off_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    !line_wake_signal_mask[0] |=> !o_event[0])
    else $error("event while event mask clear");

  reserved_zero_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    ((rising_edge_select | falling_edge_select | software_trigger
      | line_pending_flags) & ~elc_pkg::TRIG_LINES) == elc_pkg::RST_ZERO)
    else $error("line without trigger logic holds state");

  pending_hold_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (line_pending_flags[0] && !(wr_pending && i_pwdata[0]))
      |=> line_pending_flags[0])
    else $error("pending flag lost without a write of one");

  wake_reset_a: assert property (
    @(posedge i_mclk)
    !i_rst_n |=> (line_wake_signal_mask == elc_pkg::RST_ZERO
      && o_event == elc_pkg::RST_ZERO))
    else $error("event mask or event not cleared by reset");

endmodule
`default_nettype wire

// file: bench/elc_wake_model.sv
// Behavioural model of the wake-up logic fed by the line controller
`timescale 1ns/10ps
`default_nettype none
module elc_wake_model (
  input  wire logic        i_mclk,      // bus clock
  input  wire logic        i_rst_n,     // sync reset, active low
  input  wire logic [27:0] i_irq,       // interrupt levels
  input  wire logic [27:0] i_event,     // event pulses
  output logic      [7:0]  o_evt_total, // event pulses seen
  output logic      [27:0] o_irq_seen   // lines that ever raised irq
);
  // Counts every high cycle, so a stretched pulse shows as extra events
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_evt_total <= 8'h00;
    end else begin
      o_evt_total <= o_evt_total + 8'($countones(i_event));
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_irq_seen <= 28'h000_0000;
    end else begin
      o_irq_seen <= o_irq_seen | i_irq;
    end
  end
endmodule
`default_nettype wire

// file: bench/tb.sv
// Self-checking bench for the line controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module tb;
  logic        i_mclk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [27:0] line = 28'h000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [27:0] irq;
  logic [27:0] evt;
  logic [27:0] irq_seen;
  logic [7:0]  ev_total;
  logic [7:0]  ev0;
  logic [31:0] r;
  logic        e;
  int          failures = 0;
  int          check_count = 0;

  always #5 i_mclk = ~i_mclk;

  elc_top uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_line(line), .o_irq(irq), .o_event(evt));
  elc_wake_model far (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_irq(irq),
    .i_event(evt), .o_evt_total(ev_total), .o_irq_seen(irq_seen));

  // ***************
  // Bus tasks
  // ***************
  task automatic apb(input logic w, input logic [4:0] o,
                     input logic [31:0] d);
    @(posedge i_mclk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {27'h0, o};
    pwdata <= d;
    @(posedge i_mclk);
    pen <= 1'b1;
    // Wait on the slave; only the watchdog ends a hung transfer
    @(posedge i_mclk);
    while (pready !== 1'b1) begin
      @(posedge i_mclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] o, input logic [31:0] d);
    apb(1'b1, o, d);
  endtask
  task automatic rd(input logic [4:0] o, input logic [31:0] x);
    apb(1'b0, o, 32'h0000_0000);
    `CHK(r, x)
  endtask
  // Edge reaches pending within four edges; six leaves margin
  task automatic set_line(input int k, input logic v);
    ev0 = ev_total;
    @(posedge i_mclk);
    line[k] <= v;
    repeat (6) @(posedge i_mclk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #200us;
    failures++;
    tally_and_finish;
  end

  // ***************
  // Tests
  // ***************
  initial begin
    repeat (8) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rd(elc_pkg::OFS_IRQ_MASK, 32'h0f94_0000);
    `CHK(e, 1'b0)
    `CHK(pready, 1'b1)
    rd(elc_pkg::OFS_WAKE_MASK, 32'h0000_0000);
    rd(elc_pkg::OFS_RISE_SEL, 32'h0000_0000);
    rd(elc_pkg::OFS_FALL_SEL, 32'h0000_0000);
    rd(elc_pkg::OFS_SW_TRIG, 32'h0000_0000);
    wr(elc_pkg::OFS_RISE_SEL, 32'h002b_ffff);
    rd(elc_pkg::OFS_RISE_SEL, 32'h002b_ffff);
    wr(elc_pkg::OFS_PENDING, 32'h002b_ffff);
    wr(elc_pkg::OFS_IRQ_MASK, 32'h0000_0001);
    wr(elc_pkg::OFS_WAKE_MASK, 32'h0000_0001);
    set_line(0, 1'b1);
    `CHK(ev_total, ev0 + 8'h01)
    `CHK(irq, 28'h000_0001)
    rd(elc_pkg::OFS_PENDING, 32'h0000_0001);
    wr(elc_pkg::OFS_PENDING, 32'h0000_0001);
    rd(elc_pkg::OFS_PENDING, 32'h0000_0000);
    `CHK(irq, 28'h000_0000)
    set_line(0, 1'b0);
    `CHK(ev_total, ev0)
    wr(elc_pkg::OFS_FALL_SEL, 32'h0000_0001);
    set_line(0, 1'b1);
    set_line(0, 1'b0);
    `CHK(ev_total, ev0 + 8'h01)
    wr(elc_pkg::OFS_PENDING, 32'h0000_0000);
    rd(elc_pkg::OFS_PENDING, 32'h0000_0001);
    wr(elc_pkg::OFS_PENDING, 32'h0000_0001);
    wr(elc_pkg::OFS_WAKE_MASK, 32'h0000_0000);
    set_line(0, 1'b1);
    `CHK(ev_total, ev0)
    rd(elc_pkg::OFS_PENDING, 32'h0000_0001);
    wr(elc_pkg::OFS_IRQ_MASK, 32'h0040_0000);
    set_line(22, 1'b1);
    `CHK(irq, 28'h000_0000)
    wr(elc_pkg::OFS_PENDING, 32'h002b_ffff);
    wr(elc_pkg::OFS_IRQ_MASK, 32'h0008_0000);
    wr(elc_pkg::OFS_WAKE_MASK, 32'h0008_0000);
    ev0 = ev_total;
    wr(elc_pkg::OFS_SW_TRIG, 32'h0008_0008);
    rd(elc_pkg::OFS_SW_TRIG, 32'h0008_0008);
    rd(elc_pkg::OFS_PENDING, 32'h0008_0008);
    `CHK(irq, 28'h008_0000)
    `CHK(ev_total, ev0 + 8'h01)
    `CHK(irq_seen, 28'h008_0001)
    apb(1'b0, 5'h18, 32'h0000_0000);
    `CHK(e, 1'b1)
    tally_and_finish;
  end
endmodule
`default_nettype wire
